// *** src/ssdfs_feedback_regs.sv ***
// register bank for supply sync divider and feedback coefficient scaling
// Function
// - sync clock divides crystal clock per 3-bit select; 000 disables, resets to 000.
// - select 001..110 divide by 32, 64, 128, 256, 512, 1024.
// - coefficient is mantissa times two to the exponent; exponent resets to 010.
// - mantissa is 19-bit signed 1.18, resets to 25868h.
// - measurement is 24-bit signed 2.22, resets to 000000h.
// - measurement tracks external supply value; host writes ignored.
// - calibrated ripple-free supply reads 400000h, meaning 1.0.
// - coefficient in bytes 35h..37h; 35h holds exponent 6:4, mantissa 18:16.
// - measurement bytes 3Bh, 3Ch, 3Dh, most significant first.
module ssdfs_feedback_regs (
    input  wire logic                   clock_in,
    input  wire logic                   reset_in,
    input  wire ssdfs_pkg::ssdfs_addr_t reg_addr_in,
    input  wire logic                   reg_write_in,
    input  wire ssdfs_pkg::ssdfs_data_t reg_wdata_in,
    input  wire logic                   reg_read_in,
    output ssdfs_pkg::ssdfs_data_t      reg_rdata_out,
    input  wire ssdfs_pkg::ssdfs_meas_t supply_sample_in,
    input  wire logic                   supply_sample_valid_in,
    output ssdfs_pkg::ssdfs_sel_t       supply_sync_divider_sel_out,
    output ssdfs_pkg::ssdfs_shift_t     coeff_shift_out,
    output ssdfs_pkg::ssdfs_mant_t      coeff_mantissa_out,
    output ssdfs_pkg::ssdfs_meas_t      supply_measure_out,
    output ssdfs_pkg::ssdfs_meas_t      scaled_supply_out,
    output logic                        supply_sync_clock_out
);
    import ssdfs_pkg::*;

    logic        wr_cfg;
    logic        wr_hi;
    logic        wr_mid;
    logic        wr_lo;
    ssdfs_data_t next_rdata;
    ssdfs_meas_t next_scaled;

    assign wr_cfg = reg_write_in && (reg_addr_in == ADDR_SUPPLY_CFG);
    assign wr_hi  = reg_write_in && (reg_addr_in == ADDR_COEFF_HIGH);
    assign wr_mid = reg_write_in && (reg_addr_in == ADDR_COEFF_MID);
    assign wr_lo  = reg_write_in && (reg_addr_in == ADDR_COEFF_LOW);

    ////////////////////////////////////////////////////////////////////////
    // divider select
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            supply_sync_divider_sel_out <= SEL_OFF;
        end else if (wr_cfg) begin
            supply_sync_divider_sel_out <= reg_wdata_in[SEL_LSB +: SEL_W];
        end
    end

    ssdfs_sync_divider #(
        .CNT_W (DIV_CNT_W)
    ) u_divider (
        .clock_in              (clock_in),
        .reset_in              (reset_in),
        .divider_sel_in        (supply_sync_divider_sel_out),
        .supply_sync_clock_out (supply_sync_clock_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // coefficient registers
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            coeff_shift_out <= SHIFT_RESET;
        end else if (wr_hi) begin
            coeff_shift_out <= reg_wdata_in[SHIFT_LSB +: SHIFT_W];
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            coeff_mantissa_out <= MANT_RESET;
        end else begin
            if (wr_hi) begin
                coeff_mantissa_out[MANT_HI_POS +: MANT_HI_W] <= reg_wdata_in[MANT_HI_LSB +: MANT_HI_W];
            end
            if (wr_mid) begin
                coeff_mantissa_out[MANT_MID_LSB +: DATA_W] <= reg_wdata_in;
            end
            if (wr_lo) begin
                coeff_mantissa_out[0 +: DATA_W] <= reg_wdata_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // measurement word, read only
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            supply_measure_out <= MEAS_RESET;
        end else if (supply_sample_valid_in) begin
            supply_measure_out <= supply_sample_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // scaling: mantissa 1.18 times measure 2.22, shifted, back to 2.22
    function automatic ssdfs_meas_t scale(input ssdfs_mant_t m, input ssdfs_meas_t d, input ssdfs_shift_t s);
        logic signed [PROD_W-1:0] prod;
        logic signed [EXT_W-1:0]  ext;
        prod = $signed(m) * $signed(d);
        ext  = EXT_W'(prod) <<< s;
        if (ext[EXT_W-1:MANT_FRAC+MEAS_W-1] != {(EXT_W-MANT_FRAC-MEAS_W+1){ext[EXT_W-1]}}) begin
            scale = ext[EXT_W-1] ? {1'b1, {(MEAS_W-1){1'b0}}} : {1'b0, {(MEAS_W-1){1'b1}}};
        end else begin
            scale = ext[MANT_FRAC +: MEAS_W];
        end
    endfunction : scale

    assign next_scaled = scale(coeff_mantissa_out, supply_measure_out, coeff_shift_out);

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            scaled_supply_out <= MEAS_RESET;
        end else begin
            scaled_supply_out <= next_scaled;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read back, one cycle after the read strobe
    always_comb begin
        next_rdata = DATA_ZERO;
        case (reg_addr_in)
            ADDR_SUPPLY_CFG: begin
                next_rdata[SEL_LSB +: SEL_W] = supply_sync_divider_sel_out;
            end
            ADDR_COEFF_HIGH: begin
                next_rdata[SHIFT_LSB +: SHIFT_W]     = coeff_shift_out;
                next_rdata[MANT_HI_LSB +: MANT_HI_W] = coeff_mantissa_out[MANT_HI_POS +: MANT_HI_W];
            end
            ADDR_COEFF_MID: begin
                next_rdata = coeff_mantissa_out[MANT_MID_LSB +: DATA_W];
            end
            ADDR_COEFF_LOW: begin
                next_rdata = coeff_mantissa_out[0 +: DATA_W];
            end
            ADDR_MEAS_HIGH: begin
                next_rdata = supply_measure_out[MEAS_HI_LSB +: DATA_W];
            end
            ADDR_MEAS_MID: begin
                next_rdata = supply_measure_out[MEAS_MID_LSB +: DATA_W];
            end
            ADDR_MEAS_LOW: begin
                next_rdata = supply_measure_out[0 +: DATA_W];
            end
            default: begin
                next_rdata = DATA_ZERO;
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            reg_rdata_out <= DATA_ZERO;
        end else if (reg_read_in) begin
            reg_rdata_out <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);

    property p_sel_reset;
        disable iff (1'b0) reset_in |=> supply_sync_divider_sel_out == SEL_OFF && !supply_sync_clock_out;
    endproperty
    a_sel_reset: assert property (p_sel_reset) else $error("select not off after reset");

    property p_shift_reset;
        disable iff (1'b0) reset_in |=> coeff_shift_out == SHIFT_RESET;
    endproperty
    a_shift_reset: assert property (p_shift_reset) else $error("exponent reset value wrong");

    property p_mant_reset;
        disable iff (1'b0) reset_in |=> coeff_mantissa_out == MANT_RESET;
    endproperty
    a_mant_reset: assert property (p_mant_reset) else $error("mantissa reset value wrong");

    property p_meas_reset;
        disable iff (1'b0) reset_in |=> supply_measure_out == MEAS_RESET;
    endproperty
    a_meas_reset: assert property (p_meas_reset) else $error("measurement reset value wrong");

    property p_meas_track;
        supply_sample_valid_in |=> supply_measure_out == $past(supply_sample_in);
    endproperty
    a_meas_track: assert property (p_meas_track) else $error("measurement not updated");

    property p_meas_ro;
        (!supply_sample_valid_in && reg_write_in && reg_addr_in >= ADDR_MEAS_HIGH && reg_addr_in <= ADDR_MEAS_LOW)
            |=> $stable(supply_measure_out);
    endproperty
    a_meas_ro: assert property (p_meas_ro) else $error("host write changed measurement");

    property p_coeff_high_write;
        wr_hi |=> coeff_shift_out == $past(reg_wdata_in[SHIFT_LSB +: SHIFT_W])
              && coeff_mantissa_out[MANT_HI_POS +: MANT_HI_W] == $past(reg_wdata_in[MANT_HI_LSB +: MANT_HI_W]);
    endproperty
    a_coeff_high_write: assert property (p_coeff_high_write) else $error("coefficient high byte wrong");

    property p_meas_read;
        (reg_read_in && reg_addr_in == ADDR_MEAS_HIGH) |=> reg_rdata_out == $past(supply_measure_out[MEAS_HI_LSB +: DATA_W]);
    endproperty
    a_meas_read: assert property (p_meas_read) else $error("measurement high byte read wrong");

    sequence s_unity_in;
        supply_sample_valid_in && supply_sample_in == MEAS_UNITY && !reg_write_in
        && coeff_mantissa_out == 19'h2_0000 && coeff_shift_out == 3'h1;
    endsequence

    property p_unity;
        s_unity_in |=> ##1 scaled_supply_out == MEAS_UNITY;
    endproperty
    a_unity: assert property (p_unity) else $error("unity coefficient does not pass 1.0");
endmodule : ssdfs_feedback_regs

// *** src/ssdfs_pkg.sv ***
// constants for the supply sync divider and feedback scaling block
package ssdfs_pkg;
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 8;
    localparam int SEL_W      = 3;
    localparam int SHIFT_W    = 3;
    localparam int MANT_W     = 19;
    localparam int MANT_FRAC  = 18;
    localparam int MEAS_W     = 24;
    localparam int MEAS_FRAC  = 22;
    localparam int SHIFT_MAX  = 7;
    localparam int PROD_W     = MANT_W + MEAS_W;
    localparam int EXT_W      = PROD_W + SHIFT_MAX;
    localparam int DIV_CNT_W  = 10;
    localparam int DIV_BASE   = 4;

    typedef logic [ADDR_W-1:0]  ssdfs_addr_t;
    typedef logic [DATA_W-1:0]  ssdfs_data_t;
    typedef logic [SEL_W-1:0]   ssdfs_sel_t;
    typedef logic [SHIFT_W-1:0] ssdfs_shift_t;
    typedef logic [MANT_W-1:0]  ssdfs_mant_t;
    typedef logic [MEAS_W-1:0]  ssdfs_meas_t;

    localparam ssdfs_addr_t ADDR_SUPPLY_CFG  = 8'h34;
    localparam ssdfs_addr_t ADDR_COEFF_HIGH  = 8'h35;
    localparam ssdfs_addr_t ADDR_COEFF_MID   = 8'h36;
    localparam ssdfs_addr_t ADDR_COEFF_LOW   = 8'h37;
    localparam ssdfs_addr_t ADDR_MEAS_HIGH   = 8'h3B;
    localparam ssdfs_addr_t ADDR_MEAS_MID    = 8'h3C;
    localparam ssdfs_addr_t ADDR_MEAS_LOW    = 8'h3D;

    localparam int SEL_LSB      = 0;
    localparam int SHIFT_LSB    = 4;
    localparam int MANT_HI_LSB  = 0;
    localparam int MANT_HI_W    = 3;
    localparam int MANT_MID_LSB = 8;
    localparam int MANT_HI_POS  = 16;
    localparam int MEAS_MID_LSB = 8;
    localparam int MEAS_HI_LSB  = 16;

    localparam ssdfs_sel_t   SEL_OFF      = 3'h0;
    localparam ssdfs_sel_t   SEL_RESERVED = 3'h7;
    localparam ssdfs_shift_t SHIFT_RESET  = 3'h2;
    localparam ssdfs_mant_t  MANT_RESET   = 19'h2_5868;
    localparam ssdfs_meas_t  MEAS_RESET   = 24'h00_0000;
    localparam ssdfs_meas_t  MEAS_UNITY   = 24'h40_0000;
    localparam ssdfs_data_t  DATA_ZERO    = 8'h00;
endpackage : ssdfs_pkg

// *** src/ssdfs_sync_divider.sv ***
// divider producing the supply sync clock from the crystal clock
module ssdfs_sync_divider #(
    parameter int CNT_W = ssdfs_pkg::DIV_CNT_W
) (
    input  wire logic              clock_in,
    input  wire logic              reset_in,
    input  wire ssdfs_pkg::ssdfs_sel_t divider_sel_in,
    output logic                   supply_sync_clock_out
);
    import ssdfs_pkg::*;

    if (CNT_W < DIV_BASE + 6) begin : g_cnt_check
        $error("divider counter too narrow");
    end

    logic [CNT_W-1:0] count;
    logic             off;
    logic             changed;
    ssdfs_sel_t       sel_q;

    function automatic int tap_of(input ssdfs_sel_t sel);
        tap_of = int'(sel) + DIV_BASE - 1;
    endfunction : tap_of

    function automatic int divisor_of(input ssdfs_sel_t sel);
        divisor_of = 2 << tap_of(sel);
    endfunction : divisor_of

    assign off     = (divider_sel_in == SEL_OFF) || (divider_sel_in == SEL_RESERVED);
    assign changed = divider_sel_in != sel_q;

    ////////////////////////////////////////////////////////////////////////
    // select seen last cycle, restarts the phase so no short first period
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            sel_q <= SEL_OFF;
        end else begin
            sel_q <= divider_sel_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // free counter, tap bit gives 32..1024 division
    always_ff @(posedge clock_in) begin
        if (reset_in || off || changed) begin
            count <= '0;
        end else begin
            count <= count + 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in || off || changed) begin
            supply_sync_clock_out <= 1'b0;
        end else begin
            supply_sync_clock_out <= count[tap_of(divider_sel_in)];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    logic        out_q;
    logic        rise;
    logic        seen;
    logic        clean;
    logic [11:0] per_cnt;
    ssdfs_sel_t  rise_sel;

    assign rise = supply_sync_clock_out && !out_q;

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            out_q    <= 1'b0;
            seen     <= 1'b0;
            clean    <= 1'b0;
            per_cnt  <= '0;
            rise_sel <= SEL_OFF;
        end else begin
            out_q <= supply_sync_clock_out;
            if (rise) begin
                seen     <= 1'b1;
                clean    <= 1'b1;
                per_cnt  <= 12'h001;
                rise_sel <= divider_sel_in;
            end else begin
                clean   <= clean && (divider_sel_in == rise_sel);
                per_cnt <= (per_cnt == '1) ? per_cnt : per_cnt + 1'b1;
            end
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);

    property p_off_low;
        off |=> !supply_sync_clock_out;
    endproperty
    a_off_low: assert property (p_off_low) else $error("sync output not held low");

    property p_period;
        (rise && seen && clean && divider_sel_in == rise_sel) |-> int'(per_cnt) == divisor_of(divider_sel_in);
    endproperty
    a_period: assert property (p_period) else $error("sync period wrong");

    property p_runs;
        (divider_sel_in == 3'h1)[*8] |-> ##[0:40] (rise || divider_sel_in != 3'h1);
    endproperty
    a_runs: assert property (p_runs) else $error("sync clock not running");
endmodule : ssdfs_sync_divider

// *** testbench/ssdfs_supply_model.sv ***
// supply model: feeds measured samples and times the sync clock
module ssdfs_supply_model (
    input  wire logic        clock_in,
    input  wire logic        reset_in,
    input  wire logic        sync_in,
    input  wire logic        enable_in,
    input  wire logic [23:0] level_in,
    output logic [23:0]      sample_out,
    output logic             valid_out,
    output logic [11:0]      period_out,
    output logic [7:0]       rises_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        sync_q;
    logic [11:0] cnt;
    ////////////////////////////////////////////////////////////////////////////
    // sample feed, released value inverted
    always_ff @(posedge clock_in) begin
        valid_out  <= enable_in & ~reset_in;
        if (reset_in) begin
            sample_out <= 24'h5A_5A5A;
        end else begin
            sample_out <= enable_in ? level_in : ~sample_out;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // sync period in crystal cycles
    always_ff @(posedge clock_in) begin
        sync_q <= sync_in;
        if (reset_in) begin
            cnt       <= 12'h000;
            rises_out <= 8'h00;
        end else if (sync_in & ~sync_q) begin
            period_out <= cnt;
            cnt        <= 12'h001;
            rises_out  <= rises_out + 8'h01;
        end else begin
            cnt <= cnt + 12'h001;
        end
    end
endmodule : ssdfs_supply_model

// *** testbench/test_ssdfs_feedback_regs.sv ***
// self-checking bench for the feedback register bank
module test_ssdfs_feedback_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import ssdfs_pkg::*;
    logic         clock_in;
    logic         reset_in;
    ssdfs_addr_t  reg_addr_in;
    logic         reg_write_in;
    ssdfs_data_t  reg_wdata_in;
    logic         reg_read_in;
    ssdfs_data_t  reg_rdata_out;
    ssdfs_meas_t  supply_sample_in;
    logic         supply_sample_valid_in;
    ssdfs_sel_t   supply_sync_divider_sel_out;
    ssdfs_shift_t coeff_shift_out;
    ssdfs_mant_t  coeff_mantissa_out;
    ssdfs_meas_t  supply_measure_out;
    ssdfs_meas_t  scaled_supply_out;
    logic         supply_sync_clock_out;
    logic         enable;
    ssdfs_meas_t  level;
    logic [11:0]  period;
    logic [7:0]   rises;
    logic [7:0]   r;
    logic [7:0]   r0;
    int           n_errors;
    int           comparisons;
    int           i;
    int           k;
    int           lim;
    int           seed;
    ssdfs_mant_t  m;
    ssdfs_shift_t s;
    ssdfs_meas_t  x;
    ssdfs_sel_t   sels [8] = '{3'h6, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};

    ssdfs_feedback_regs dut (.clock_in, .reset_in, .reg_addr_in, .reg_write_in, .reg_wdata_in, .reg_read_in,
        .reg_rdata_out, .supply_sample_in, .supply_sample_valid_in, .supply_sync_divider_sel_out,
        .coeff_shift_out, .coeff_mantissa_out, .supply_measure_out, .scaled_supply_out, .supply_sync_clock_out);

    ssdfs_supply_model partner (.clock_in(clock_in), .reset_in(reset_in), .sync_in(supply_sync_clock_out),
        .enable_in(enable), .level_in(level), .sample_out(supply_sample_in),
        .valid_out(supply_sample_valid_in), .period_out(period), .rises_out(rises));
    ////////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    task automatic check(string what, logic [23:0] e, logic [23:0] g);
        comparisons++;
        if (e !== g) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : check

    task automatic access(ssdfs_addr_t a, logic wr, ssdfs_data_t d);
        @(posedge clock_in);
        reg_addr_in  <= a;
        reg_write_in <= wr;
        reg_read_in  <= ~wr;
        reg_wdata_in <= d;
        @(posedge clock_in);
        reg_write_in <= 1'b0;
        reg_read_in  <= 1'b0;
        #1;
    endtask : access

    task automatic rd(ssdfs_addr_t a, ssdfs_data_t e);
        access(a, 1'b0, 8'h00);
        check("reg_rdata_out", e, reg_rdata_out);
    endtask : rd

    task automatic feed(ssdfs_meas_t v);
        @(posedge clock_in);
        level  <= v;
        enable <= 1'b1;
        @(posedge clock_in);
        enable <= 1'b0;
        repeat (3) @(posedge clock_in);
        #1;
    endtask : feed

    // coefficient scaling, saturating 2.22
    function automatic ssdfs_meas_t exp_scaled(ssdfs_mant_t mm, ssdfs_shift_t ss, ssdfs_meas_t xx);
        logic signed [49:0] p;
        p = ($signed(mm) * $signed(xx)) <<< ss;
        p = p >>> 18;
        if (p > 50'sh7F_FFFF) return 24'h7F_FFFF;
        if (p < -50'sh80_0000) return 24'h80_0000;
        return p[23:0];
    endfunction : exp_scaled
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end

    initial begin
        reset_in     = 1'b1;
        reg_addr_in  = 8'h00;
        reg_write_in = 1'b0;
        reg_wdata_in = 8'h00;
        reg_read_in  = 1'b0;
        enable       = 1'b0;
        level        = 24'h00_0000;
        seed         = $urandom(32'hd1a0);
        repeat (8) @(posedge clock_in);
        reset_in <= 1'b0;
        // reset values and unmapped read
        rd(8'h34, 8'h00);
        rd(8'h35, 8'h22);
        rd(8'h36, 8'h58);
        rd(8'h37, 8'h68);
        rd(8'h3B, 8'h00);
        rd(8'h3D, 8'h00);
        rd(8'h40, 8'h00);
        // coefficient corners then random
        for (i = 0; i < 20; i++) begin
            m = (i == 0) ? 19'h2_0000 : (i == 1) ? 19'h3_FFFF : (i == 2) ? 19'h4_0000 : 19'($urandom);
            s = (i == 0) ? 3'h1 : (i < 3) ? 3'h7 : 3'($urandom);
            x = (i == 0) ? MEAS_UNITY : (i < 3) ? 24'h7F_FFFF : 24'($urandom);
            r = 8'($urandom);
            access(8'h35, 1'b1, {r[0], s, r[1], m[18:16]});
            access(8'h36, 1'b1, m[15:8]);
            access(8'h37, 1'b1, m[7:0]);
            feed(x);
            check("coeff_shift_out", s, coeff_shift_out);
            check("coeff_mantissa_out", m, coeff_mantissa_out);
            check("scaled_supply_out", exp_scaled(m, s, x), scaled_supply_out);
            access(8'h3B, 1'b1, ~x[23:16]);
            rd(8'h3B, x[23:16]);
            rd(8'h3C, x[15:8]);
            rd(8'h3D, x[7:0]);
            rd(8'h35, {1'b0, s, 1'b0, m[18:16]});
            rd(8'h36, m[15:8]);
            rd(8'h37, m[7:0]);
        end
        // sync divider for every select code
        for (i = 0; i < 8; i++) begin
            access(8'h34, 1'b1, {5'h1F, sels[i]});
            rd(8'h34, {5'h00, sels[i]});
            r0  = rises;
            k   = 0;
            lim = (sels[i] == 3'h0 || sels[i] == 3'h7) ? 2100 : 3 * (32 << (sels[i] - 1)) + 40;
            while (k < lim && 8'(rises - r0) < 8'h03) begin
                @(posedge clock_in);
                k++;
            end
            if (sels[i] == 3'h0 || sels[i] == 3'h7) begin
                check("sync_rises", 0, rises - r0);
                check("supply_sync_clock_out", 0, supply_sync_clock_out);
            end else if (k >= lim) begin
                n_errors++;
                $display("wrong value sync_rises expected 3 seen %0d", 8'(rises - r0));
                results();
            end else begin
                check("sync_period", 32 << (sels[i] - 1), period);
            end
        end
        // mid-run reset restores defaults
        access(8'h34, 1'b1, 8'h01);
        @(posedge clock_in);
        reset_in <= 1'b1;
        @(posedge clock_in);
        reset_in <= 1'b0;
        #1;
        check("coeff_shift_out", SHIFT_RESET, coeff_shift_out);
        check("coeff_mantissa_out", MANT_RESET, coeff_mantissa_out);
        check("supply_measure_out", MEAS_RESET, supply_measure_out);
        check("supply_sync_divider_sel_out", SEL_OFF, supply_sync_divider_sel_out);
        results();
    end
endmodule : test_ssdfs_feedback_regs
